// ==== fspc_pkg.sv ====
// Shared constants and types for the flash self-program controller.
// What this block does
// (R1) Address is page low byte plus effective address.
// (R2) Low table ops reach bits 15..0, word/byte.
// (R3) High table ops reach bits 23..16, word/byte.
// (R4) Rows hold 64 words; pages hold eight rows.
// (R5) Pages and rows align from memory start.
// (R6) Holding buffer keeps one aligned 64-word group.
// (R7) Software loads 64 low and 64 high writes.
// (R8) Table writes fill buffer only, two cycles.
// (R9) Processor stalls while an operation runs.
// (R10) Duration counted in oscillator ticks; row 11064.
// (R11) Start bit begins operation, hardware clears it.
// (R12) Software writes 0x55 then 0xAA to key.
// (R13) Enable bit allows or inhibits operations.
// (R14) Error flag marks bad sequence or termination.
// (R15) Erase select picks erase or program.
// (R16) Erase codes decode as listed.
// (R17) Program codes decode as listed.
// (R18) Unlisted codes count as unimplemented.
// (R19) Control bits reset to zero on power-on.
// (R20) Start only settable; unused bits read zero.
// (R21) Page bit 7 selects configuration space.
// (R22) Software places two idle instructions after start.
// (R23) Bad start is ignored and flags an error.
// (R24) Key register always reads zero.
package fspc_pkg;
    // Register word addresses on the software port.
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_KEY = 2'h1;
    localparam logic [1:0] ADDR_PAGE = 2'h2;
    // Control register field positions.
    localparam int BIT_START = 15;
    localparam int BIT_ENABLE = 14;
    localparam int BIT_ERROR = 13;
    localparam int BIT_ERASE = 6;
    // Reset value of every control field.
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    // Unlock key values.
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // Operation codes.
    localparam logic [3:0] OP_BULK = 4'hF;
    localparam logic [3:0] OP_GENERAL = 4'hD;
    localparam logic [3:0] OP_SECURE = 4'hC;
    localparam logic [3:0] OP_WORD = 4'h3;
    localparam logic [3:0] OP_PAGE = 4'h2;
    localparam logic [3:0] OP_ROW = 4'h1;
    localparam logic [3:0] OP_CONFIG = 4'h0;
    // Array geometry in instruction words.
    localparam int ROW_WORDS = 64;
    localparam int ROW_IDX_BITS = 6;
    localparam int PAGE_ADDR_BITS = 10;
    localparam int ROW_ADDR_BITS = 7;
    // Default operation durations in oscillator ticks.
    localparam int ROW_TICKS = 11064;
    localparam int ERASE_TICKS = 8192;
    localparam int WORD_TICKS = 256;
    // Table request from the processor.
    typedef struct packed {
        logic valid;
        logic write;
        logic high;
        logic byteMode;
        logic [15:0] ea;
        logic [15:0] wdata;
    } fspc_table_req_type;
    // Command handed to the flash array.
    typedef struct packed {
        logic go;
        logic erase;
        logic configSpace;
        logic [3:0] op;
        logic [23:0] addr;
    } fspc_flash_cmd_type;
    // Sequencer states.
    typedef enum logic {ST_IDLE, ST_BUSY} fspc_state_type;
endpackage : fspc_pkg

// ==== fspc_controller.sv ====
// Flash self-program controller: registers, holding buffer, sequencer.
`timescale 1ns/1ps
`default_nettype none
module fspc_controller #(
    parameter int ROW_TICKS = fspc_pkg::ROW_TICKS,
    parameter int ERASE_TICKS = fspc_pkg::ERASE_TICKS,
    parameter int WORD_TICKS = fspc_pkg::WORD_TICKS
) (
    // Clock and power-on reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Software register port.
    input wire logic [1:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdata,
    // Table instruction port.
    input wire fspc_pkg::fspc_table_req_type tblReq,
    output logic [15:0] tblRdata,
    output logic tblRdValid,
    output logic tblWrDone,
    // Flash array side.
    output logic flashRdEn,
    output logic [23:0] flashRdAddr,
    input wire logic [23:0] flashRdData,
    output fspc_pkg::fspc_flash_cmd_type flashCmd,
    input wire logic frcTick,
    input wire logic flashFault,
    input wire logic [5:0] bufRdIdx,
    output logic [23:0] bufRdWord,
    // Processor stall.
    output logic cpuStall
);
    // Control register fields.
    logic startBit, next_startBit;
    logic enable, next_enable;
    logic errFlag, next_errFlag;
    logic eraseSel, next_eraseSel;
    logic [3:0] opSel, next_opSel;
    // Key progress: 0 none, 1 first key seen, 2 armed.
    logic [1:0] keyStage, next_keyStage;
    // Sequencer state and remaining ticks.
    fspc_pkg::fspc_state_type state, next_state;
    logic [15:0] ticks, next_ticks;
    // Table page and latched buffer target.
    logic [7:0] page, next_page;
    logic [23:0] target, next_target;
    // Outgoing registered signals.
    logic [15:0] next_regRdata;
    fspc_pkg::fspc_flash_cmd_type next_flashCmd;
    logic next_cpuStall;
    // Holding buffer for one row.
    logic [23:0] holdBuf [fspc_pkg::ROW_WORDS];

    // Decoded software accesses.
    logic ctrlWr, keyWr, pageWr, startTry, startOk;
    // Decoded operation class.
    logic opTimed, opNop;
    logic [15:0] opTicks;

    // Decode the operation code for the current erase choice.
    always_comb begin
        opTimed = 1'b0;
        opNop = 1'b0;
        opTicks = 16'h0001;
        if (eraseSel) begin // R15
            // Erase codes.
            if (opSel == fspc_pkg::OP_BULK || opSel == fspc_pkg::OP_GENERAL ||
                opSel == fspc_pkg::OP_SECURE || opSel == fspc_pkg::OP_PAGE ||
                opSel == fspc_pkg::OP_CONFIG) begin // R16
                opTimed = 1'b1;
                opTicks = ERASE_TICKS[15:0];
            end else if (opSel == fspc_pkg::OP_WORD || opSel == fspc_pkg::OP_ROW) begin
                opNop = 1'b1; // R16
            end
        end else begin
            // Program codes.
            if (opSel == fspc_pkg::OP_ROW) begin // R17
                opTimed = 1'b1;
                opTicks = ROW_TICKS[15:0]; // R10
            end else if (opSel == fspc_pkg::OP_WORD || opSel == fspc_pkg::OP_CONFIG) begin
                opTimed = 1'b1;
                opTicks = WORD_TICKS[15:0];
            end else if (opSel == fspc_pkg::OP_BULK || opSel == fspc_pkg::OP_GENERAL ||
                         opSel == fspc_pkg::OP_SECURE || opSel == fspc_pkg::OP_PAGE) begin
                opNop = 1'b1; // R17
            end
        end
        // Reserved and other codes stay neither timed nor idle: unimplemented.
    end // R18

    // Register writes, key tracking, sequencer and read data.
    always_comb begin
        ctrlWr = regWrite && regAddr == fspc_pkg::ADDR_CONTROL && state == fspc_pkg::ST_IDLE;
        keyWr = regWrite && regAddr == fspc_pkg::ADDR_KEY;
        pageWr = regWrite && regAddr == fspc_pkg::ADDR_PAGE;
        startTry = ctrlWr && regWdata[fspc_pkg::BIT_START] && !startBit;
        startOk = startTry && enable && keyStage == 2'h2 && (opTimed || opNop); // R13 R23
        next_startBit = startBit;
        next_enable = enable;
        next_errFlag = errFlag;
        next_eraseSel = eraseSel;
        next_opSel = opSel;
        next_keyStage = keyStage;
        next_state = state;
        next_ticks = ticks;
        next_page = page;
        next_flashCmd = flashCmd;
        next_flashCmd.go = 1'b0;
        // Any write breaks the key sequence unless it continues it.
        if (regWrite) begin
            next_keyStage = 2'h0;
            if (keyWr && regWdata[7:0] == fspc_pkg::KEY_FIRST) begin
                next_keyStage = 2'h1;
            end else if (keyWr && regWdata[7:0] == fspc_pkg::KEY_SECOND && keyStage == 2'h1) begin
                next_keyStage = 2'h2;
            end
        end
        // Software writes to the control fields; start can only be set.
        if (ctrlWr) begin
            next_enable = regWdata[fspc_pkg::BIT_ENABLE];
            next_errFlag = regWdata[fspc_pkg::BIT_ERROR];
            next_eraseSel = regWdata[fspc_pkg::BIT_ERASE];
            next_opSel = regWdata[3:0];
        end // R20
        if (pageWr) begin
            next_page = regWdata[7:0];
        end
        // A start attempt launches, is refused with an error, or for a no-operation code only clears the error.
        if (startTry && !startOk) begin
            next_errFlag = 1'b1; // R14 R23
        end else if (startOk && opNop) begin
            next_errFlag = 1'b0;
        end else if (startOk) begin
            next_startBit = 1'b1; // R11
            next_errFlag = 1'b0;
            next_state = fspc_pkg::ST_BUSY;
            next_ticks = opTicks;
            next_flashCmd.go = 1'b1;
            next_flashCmd.erase = eraseSel;
            next_flashCmd.op = opSel;
            next_flashCmd.configSpace = target[23]; // R21
            next_flashCmd.addr = target;
            if (eraseSel) begin
                next_flashCmd.addr = {target[23:fspc_pkg::PAGE_ADDR_BITS],
                                      {fspc_pkg::PAGE_ADDR_BITS{1'b0}}}; // R5
            end else if (opSel == fspc_pkg::OP_ROW) begin
                next_flashCmd.addr = {target[23:fspc_pkg::ROW_ADDR_BITS],
                                      {fspc_pkg::ROW_ADDR_BITS{1'b0}}}; // R4 R5
            end
        end
        // Count oscillator ticks; a fault ends the operation with an error.
        if (state == fspc_pkg::ST_BUSY) begin
            if (flashFault) begin
                next_state = fspc_pkg::ST_IDLE;
                next_startBit = 1'b0;
                next_errFlag = 1'b1; // R14
            end else if (frcTick) begin
                next_ticks = ticks - 16'h0001; // R10
                if (ticks == 16'h0001) begin
                    next_state = fspc_pkg::ST_IDLE;
                    next_startBit = 1'b0; // R11
                end
            end
        end
        next_cpuStall = next_state == fspc_pkg::ST_BUSY; // R9
        // Read data: unused bits and the key read as zero.
        next_regRdata = 16'h0000;
        if (regRead && regAddr == fspc_pkg::ADDR_CONTROL) begin
            next_regRdata = fspc_pkg::CONTROL_RESET;
            next_regRdata[fspc_pkg::BIT_START] = startBit;
            next_regRdata[fspc_pkg::BIT_ENABLE] = enable;
            next_regRdata[fspc_pkg::BIT_ERROR] = errFlag;
            next_regRdata[fspc_pkg::BIT_ERASE] = eraseSel;
            next_regRdata[3:0] = opSel; // R20
        end else if (regRead && regAddr == fspc_pkg::ADDR_PAGE) begin
            next_regRdata = {8'h00, page};
        end // R24
    end

    // Register the control group; power-on reset clears all.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            startBit <= 1'b0; // R19
            enable <= 1'b0;
            errFlag <= 1'b0;
            eraseSel <= 1'b0;
            opSel <= 4'h0;
            keyStage <= 2'h0;
            state <= fspc_pkg::ST_IDLE;
            ticks <= 16'h0000;
            page <= 8'h00;
            flashCmd <= '0;
            regRdata <= 16'h0000;
            cpuStall <= 1'b0;
        end else begin
            startBit <= next_startBit;
            enable <= next_enable;
            errFlag <= next_errFlag;
            eraseSel <= next_eraseSel;
            opSel <= next_opSel;
            keyStage <= next_keyStage;
            state <= next_state;
            ticks <= next_ticks;
            page <= next_page;
            flashCmd <= next_flashCmd;
            regRdata <= next_regRdata;
            cpuStall <= next_cpuStall;
        end
    end

    // Table path state.
    logic next_flashRdEn, rdWait, next_rdWait;
    logic rdHigh, next_rdHigh, rdByte, next_rdByte, rdOdd, next_rdOdd;
    logic [23:0] next_flashRdAddr, tblAddr;
    logic [15:0] next_tblRdata;
    logic next_tblRdValid, next_tblWrDone;
    logic [5:0] bufIdx;
    logic [23:0] bufOld, bufNew;

    // Compute table reads, buffer updates and the write target.
    always_comb begin
        tblAddr = {page, tblReq.ea}; // R1
        bufIdx = tblReq.ea[fspc_pkg::ROW_IDX_BITS:1]; // R6
        bufOld = holdBuf[bufIdx];
        bufNew = bufOld;
        next_target = target;
        next_flashRdEn = tblReq.valid && !tblReq.write;
        next_flashRdAddr = next_flashRdEn ? tblAddr : flashRdAddr;
        next_rdWait = flashRdEn;
        next_rdHigh = flashRdEn ? rdHigh : tblReq.high;
        next_rdByte = flashRdEn ? rdByte : tblReq.byteMode;
        next_rdOdd = flashRdEn ? rdOdd : tblReq.ea[0];
        next_tblWrDone = tblReq.valid && tblReq.write; // R8
        if (tblReq.valid && tblReq.write) begin
            next_target = tblAddr;
            if (!tblReq.high && !tblReq.byteMode) begin
                bufNew[15:0] = tblReq.wdata; // R2
            end else if (!tblReq.high && tblReq.ea[0]) begin
                bufNew[15:8] = tblReq.wdata[7:0];
            end else if (!tblReq.high) begin
                bufNew[7:0] = tblReq.wdata[7:0];
            end else if (!tblReq.byteMode || !tblReq.ea[0]) begin
                bufNew[23:16] = tblReq.wdata[7:0]; // R3
            end
        end
        // Shape returned data; the phantom upper byte is zero.
        next_tblRdata = tblRdata;
        next_tblRdValid = rdWait;
        if (rdWait) begin
            if (!rdHigh && !rdByte) begin
                next_tblRdata = flashRdData[15:0]; // R2
            end else if (!rdHigh) begin
                next_tblRdata = {8'h00, rdOdd ? flashRdData[15:8] : flashRdData[7:0]};
            end else if (rdByte && rdOdd) begin
                next_tblRdata = 16'h0000; // R3
            end else begin
                next_tblRdata = {8'h00, flashRdData[23:16]}; // R3
            end
        end
    end

    // Register the table group.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flashRdEn <= 1'b0;
            flashRdAddr <= 24'h000000;
            rdWait <= 1'b0;
            rdHigh <= 1'b0;
            rdByte <= 1'b0;
            rdOdd <= 1'b0;
            target <= 24'h000000;
            tblRdata <= 16'h0000;
            tblRdValid <= 1'b0;
            tblWrDone <= 1'b0;
            bufRdWord <= 24'h000000;
        end else begin
            flashRdEn <= next_flashRdEn;
            flashRdAddr <= next_flashRdAddr;
            rdWait <= next_rdWait;
            rdHigh <= next_rdHigh;
            rdByte <= next_rdByte;
            rdOdd <= next_rdOdd;
            target <= next_target;
            tblRdata <= next_tblRdata;
            tblRdValid <= next_tblRdValid;
            tblWrDone <= next_tblWrDone;
            bufRdWord <= holdBuf[bufRdIdx];
        end
    end

    // Holding buffer storage; contents are not reset.
    always_ff @(posedge sys_clk) begin
        if (tblReq.valid && tblReq.write) begin
            holdBuf[bufIdx] <= bufNew; // R6 R8
        end
    end

    // Helper: ticks counted during a row program.
    logic [15:0] seenTicks;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            seenTicks <= 16'h0000;
        end else if (startOk) begin
            seenTicks <= 16'h0000;
        end else if (state == fspc_pkg::ST_BUSY && frcTick && !flashFault) begin
            seenTicks <= seenTicks + 16'h0001;
        end
    end

    property p_bad_start;
        @(posedge sys_clk) disable iff (rst)
        (startTry && !(enable && keyStage == 2'h2)) |=> (errFlag && !startBit);
    endproperty
    a_bad_start: assert property (p_bad_start) else $error("refused start changed state"); // R23

    property p_inhibit;
        @(posedge sys_clk) disable iff (rst)
        (startTry && !enable) |=> ##1 (state == fspc_pkg::ST_IDLE && !flashCmd.go);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("disabled start ran"); // R13

    property p_stall;
        @(posedge sys_clk) disable iff (rst)
        flashCmd.go |-> (cpuStall && startBit);
    endproperty
    a_stall: assert property (p_stall) else $error("operation without stall"); // R9

    property p_done_clears;
        @(posedge sys_clk) disable iff (rst)
        $fell(cpuStall) |-> !startBit;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("start bit left set"); // R11

    property p_row_len;
        @(posedge sys_clk) disable iff (rst)
        ($fell(startBit) && !flashCmd.erase && flashCmd.op == fspc_pkg::OP_ROW && !errFlag)
        |-> seenTicks == ROW_TICKS[15:0];
    endproperty
    a_row_len: assert property (p_row_len) else $error("row time wrong"); // R10

    property p_key_zero;
        @(posedge sys_clk) disable iff (rst)
        (regRead && regAddr == fspc_pkg::ADDR_KEY) |=> regRdata == 16'h0000;
    endproperty
    a_key_zero: assert property (p_key_zero) else $error("key read not zero"); // R24

    property p_unused_zero;
        @(posedge sys_clk) disable iff (rst)
        (regRead && regAddr == fspc_pkg::ADDR_CONTROL) |=> (regRdata[12:7] == 6'h00 && regRdata[5:4] == 2'h0);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits set"); // R20

    property p_addr_form;
        @(posedge sys_clk) disable iff (rst)
        (tblReq.valid && !tblReq.write) |=> (flashRdEn && flashRdAddr == {$past(page), $past(tblReq.ea)});
    endproperty
    a_addr_form: assert property (p_addr_form) else $error("table address wrong"); // R1

    property p_phantom;
        @(posedge sys_clk) disable iff (rst)
        (tblReq.valid && !tblReq.write && tblReq.high) |-> ##3 (tblRdValid && tblRdata[15:8] == 8'h00);
    endproperty
    a_phantom: assert property (p_phantom) else $error("high read upper byte set"); // R3
endmodule : fspc_controller
`default_nettype wire

// ==== fspc_controller_bench.sv ====
// Self-checking bench for the flash self-program controller.
`timescale 1ns/1ps
`default_nettype none
module fspc_controller_bench;
    // Shortened operation lengths, in oscillator ticks.
    localparam int ROWT = 8;
    localparam int ERAT = 4;
    localparam int WRDT = 2;
    // Design inputs, all given a value at time zero.
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] regAddr = 2'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    fspc_pkg::fspc_table_req_type tblReq = '0;
    logic [23:0] flashRdData = 24'h000000;
    logic frcTick = 1'b0;
    logic flashFault = 1'b0;
    logic [5:0] bufRdIdx = 6'h00;
    // Design outputs.
    logic [15:0] regRdata;
    logic [15:0] tblRdata;
    logic tblRdValid;
    logic tblWrDone;
    logic flashRdEn;
    logic [23:0] flashRdAddr;
    fspc_pkg::fspc_flash_cmd_type flashCmd;
    logic [23:0] bufRdWord;
    logic cpuStall;
    // Bench state: counters, generator and reference model.
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] rngState = 32'hE57FAF6E;
    logic tickOn = 1'b0;
    logic [23:0] bufModel [64];
    logic [7:0] page = 8'h00;
    logic [23:0] target = 24'h000000;
    logic [15:0] got;

    fspc_controller #(.ROW_TICKS(ROWT), .ERASE_TICKS(ERAT), .WORD_TICKS(WRDT)) dut (
        .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .tblReq(tblReq),
        .tblRdata(tblRdata), .tblRdValid(tblRdValid), .tblWrDone(tblWrDone),
        .flashRdEn(flashRdEn), .flashRdAddr(flashRdAddr), .flashRdData(flashRdData),
        .flashCmd(flashCmd), .frcTick(frcTick), .flashFault(flashFault),
        .bufRdIdx(bufRdIdx), .bufRdWord(bufRdWord), .cpuStall(cpuStall));

    // Free-running 100 MHz clock.
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // Xorshift generator with a fixed start.
    function automatic logic [31:0] xs();
        rngState ^= rngState << 13;
        rngState ^= rngState >> 17;
        rngState ^= rngState << 5;
        return rngState;
    endfunction : xs

    // Random oscillator ticks while enabled, and the hang guard.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        frcTick <= tickOn & (xs() > 32'h7FFFFFFF);
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    // Prints the counts and the verdict, then stops.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [23:0] g, input logic [23:0] e, input string m);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    // One register write cycle.
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask : wr

    // One register read; data is taken in the following cycle.
    task automatic rd(input logic [1:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 got = regRdata;
    endtask : rd

    // Unlock key followed by a control write; returns in the cycle after.
    task automatic st(input logic [15:0] ctl);
        wr(fspc_pkg::ADDR_KEY, {8'h00, fspc_pkg::KEY_FIRST});
        wr(fspc_pkg::ADDR_KEY, {8'h00, fspc_pkg::KEY_SECOND});
        wr(fspc_pkg::ADDR_CONTROL, ctl);
        #1;
    endtask : st

    // Table write with the model updated the same way.
    task automatic tw(input logic h, input logic b, input logic [15:0] ea, input logic [15:0] wd);
        int i;
        i = int'(ea[6:1]);
        @(posedge sys_clk);
        tblReq <= {1'b1, 1'b1, h, b, ea, wd};
        @(posedge sys_clk);
        tblReq.valid <= 1'b0;
        #1 chk(24'(tblWrDone), 24'h000001, "write done");
        target = {page, ea};
        if (!h && !b) bufModel[i][15:0] = wd;
        else if (!h && ea[0]) bufModel[i][15:8] = wd[7:0];
        else if (!h) bufModel[i][7:0] = wd[7:0];
        else if (!b || !ea[0]) bufModel[i][23:16] = wd[7:0];
    endtask : tw

    // Table read with a random array word and the expected lane.
    task automatic tr(input logic h, input logic b, input logic [15:0] ea);
        logic [23:0] d;
        logic [23:0] e;
        d = 24'(xs());
        if (!h) e = b ? (ea[0] ? 24'(d[15:8]) : 24'(d[7:0])) : 24'(d[15:0]);
        else e = (b && ea[0]) ? 24'h000000 : 24'(d[23:16]);
        @(posedge sys_clk);
        tblReq <= {1'b1, 1'b0, h, b, ea, 16'h0000};
        @(posedge sys_clk);
        tblReq.valid <= 1'b0;
        #1 chk(24'(flashRdEn), 24'h000001, "read request");
        chk(flashRdAddr, {page, ea}, "read address");
        @(posedge sys_clk);
        flashRdData <= d;
        @(posedge sys_clk);
        flashRdData <= ~d;
        #1 chk(24'(tblRdValid), 24'h000001, "read valid");
        chk(24'(tblRdata), e, "read lane");
    endtask : tr

    // Lets ticks run and, for a positive n, checks the stall length against the tick count.
    task automatic waitOp(input int n);
        int cnt;
        int extra;
        int lim;
        logic t;
        cnt = 0;
        extra = 0;
        tickOn = 1'b1;
        for (lim = 0; lim < 400 && cpuStall === 1'b1; lim++) begin
            t = frcTick;
            @(posedge sys_clk);
            #1;
            if (n > 0 && cnt == n) extra++;
            if (t === 1'b1 && (n < 0 || cnt < n)) cnt++;
        end
        tickOn = 1'b0;
        chk(24'(cpuStall), 24'h000000, "stall end");
        if (n > 0) begin
            chk(24'(cnt), 24'(n), "ticks");
            chk(24'(extra > 1), 24'h000000, "late end");
        end
    endtask : waitOp

    // Outcome class of a code: 0 timed, 1 no operation, 2 refused.
    function automatic int cls(input logic e, input logic [3:0] op);
        if (e) begin
            case (op)
                4'hF, 4'hD, 4'hC, 4'h2, 4'h0: return 0;
                4'h3, 4'h1: return 1;
                default: return 2;
            endcase
        end
        case (op)
            4'h3, 4'h1, 4'h0: return 0;
            4'hF, 4'hD, 4'hC, 4'h2: return 1;
            default: return 2;
        endcase
    endfunction : cls

    // Main sequence.
    initial begin
        int c;
        int n;
        logic [23:0] ex;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            rd(2'(a));
            chk(24'(got), 24'h000000, "reset value");
        end
        $display("test reset done");
        wr(fspc_pkg::ADDR_CONTROL, 16'h3FFF);
        rd(fspc_pkg::ADDR_CONTROL);
        chk(24'(got), 24'h00204F, "unused bits");
        wr(fspc_pkg::ADDR_KEY, 16'h0055);
        rd(fspc_pkg::ADDR_KEY);
        chk(24'(got), 24'h000000, "key read");
        wr(fspc_pkg::ADDR_CONTROL, 16'h0000);
        wr(fspc_pkg::ADDR_CONTROL, 16'hC001);
        rd(fspc_pkg::ADDR_CONTROL);
        chk(24'(got), 24'h006001, "start without key");
        wr(fspc_pkg::ADDR_CONTROL, 16'h0000);
        st(16'h8001);
        rd(fspc_pkg::ADDR_CONTROL);
        chk(24'(got), 24'h002001, "start disabled");
        for (int k = 0; k < 2; k++) begin
            wr(fspc_pkg::ADDR_CONTROL, 16'h0000);
            wr(fspc_pkg::ADDR_KEY, 16'h0055);
            wr(fspc_pkg::ADDR_KEY, 16'h00AA);
            wr(k ? 2'h3 : fspc_pkg::ADDR_PAGE, 16'h0000);
            wr(fspc_pkg::ADDR_CONTROL, 16'hC001);
            rd(fspc_pkg::ADDR_CONTROL);
            chk(24'(got), 24'h006001, "broken key");
        end
        $display("test control done");
        for (int i = 0; i < 64; i++) begin
            tw(1'b0, 1'b0, 16'h0080 + 16'(2 * i), 16'(xs()));
            tw(1'b1, 1'b0, 16'h0080 + 16'(2 * i), 16'(xs()));
        end
        tw(1'b0, 1'b1, 16'h008B, 16'(xs()));
        tw(1'b1, 1'b1, 16'h008B, 16'(xs()));
        tw(1'b1, 1'b1, 16'h008A, 16'(xs()));
        for (int i = 0; i < 64; i++) begin
            @(posedge sys_clk);
            bufRdIdx <= 6'(i);
            repeat (2) @(posedge sys_clk);
            #1 chk(bufRdWord, bufModel[i], "buffer word");
        end
        $display("test buffer done");
        for (int e = 0; e < 2; e++) begin
            page = e ? 8'h81 : 8'h00;
            wr(fspc_pkg::ADDR_PAGE, {8'h00, page});
            tw(1'b0, 1'b0, 16'h1ABE, 16'(xs()));
            for (int op = 0; op < 16; op++) begin
                c = cls(e[0], 4'(op));
                n = (e && op == 2) ? ERAT : (!e && op == 1) ? ROWT : (!e && op == 3) ? WRDT : -1;
                ex = e ? (target & 24'hFFFC00) : (op == 1 ? (target & 24'hFFFF80) : target);
                wr(fspc_pkg::ADDR_CONTROL, 16'h4000 | 16'(e << 6) | 16'(op));
                st(16'hC000 | 16'(e << 6) | 16'(op));
                if (c == 0) begin
                    chk(24'(cpuStall), 24'h000001, "stall start");
                    chk(24'(flashCmd.go), 24'h000001, "go");
                    chk(24'(flashCmd.erase), 24'(e), "erase select");
                    chk(24'(flashCmd.op), 24'(op), "op code");
                    chk(24'(flashCmd.configSpace), 24'(page[7]), "space");
                    chk(flashCmd.addr, ex, "aligned address");
                    waitOp(n);
                end else begin
                    chk(24'(cpuStall), 24'h000000, "no stall");
                end
                rd(fspc_pkg::ADDR_CONTROL);
                chk(24'(got), 24'h004000 | (c == 2 ? 24'h002000 : 24'h0) | 24'(e << 6) | 24'(op),
                    "outcome");
            end
        end
        $display("test codes done");
        wr(fspc_pkg::ADDR_CONTROL, 16'h4001);
        st(16'hC001);
        chk(24'(cpuStall), 24'h000001, "fault start");
        @(posedge sys_clk);
        flashFault <= 1'b1;
        @(posedge sys_clk);
        flashFault <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 chk(24'(cpuStall), 24'h000000, "fault end");
        rd(fspc_pkg::ADDR_CONTROL);
        chk(24'(got), 24'h006001, "fault flag");
        $display("test fault done");
        for (int m = 0; m < 8; m++) begin
            tr(m[2], m[1], 16'h0100 | 16'(m[0]));
        end
        $display("test read done");
        give_verdict();
    end
endmodule : fspc_controller_bench
`default_nettype wire
